/* File: logic/ocr_pkg.sv */
// Constants and types for the oscillator control register block
package ocr_pkg;
    // Register byte offsets on the register bus
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TUNING  = 8'h04;
    localparam logic [7:0] OFS_TUNING2 = 8'h08;
    localparam logic [7:0] OFS_PRTRIM  = 8'h0c;
    localparam int         ADDR_W      = 8;

    // Control register fields
    localparam int CUR_LSB  = 12;
    localparam int REQ_LSB  = 8;
    localparam int LOCK_BIT = 7;
    localparam int PLLL_BIT = 5;
    localparam int DITH_BIT = 4;
    localparam int FAIL_BIT = 3;
    localparam int TSEQ_BIT = 2;
    localparam int SWRQ_BIT = 0;
    localparam int GRP_W    = 3;
    localparam int TRIM_W   = 4;
    localparam int PRT_W    = 15;

    // Clock group codes
    localparam logic [2:0] GRP_RC      = 3'h0;
    localparam logic [2:0] GRP_RC_PLL  = 3'h1;
    localparam logic [2:0] GRP_PRI     = 3'h2;
    localparam logic [2:0] GRP_PRI_PLL = 3'h3;

    // Trim source and dither constants
    localparam logic [2:0]  PHASE_BASE = 3'h0;
    localparam logic [14:0] PRT_RESET  = 15'h0000;
    localparam logic [14:0] PRT_SEED   = 15'h0001;
    localparam int          PRT_TAP_A  = 14;
    localparam int          PRT_TAP_B  = 13;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_CONTROL = 3'b000,
        SEL_TUNING  = 3'b001,
        SEL_TUNING2 = 3'b010,
        SEL_PRTRIM  = 3'b011,
        SEL_NONE    = 3'b100
    } ocr_sel_t;

    typedef struct packed {
        logic                aw_held;
        logic [ADDR_W-1:0]   aw_addr;
        logic                w_held;
        logic [15:0]         w_data;
        logic [1:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [15:0]         rdata;
        logic [1:0]          rresp;
        logic [GRP_W-1:0]    current_group;
        logic [GRP_W-1:0]    requested_group;
        logic                config_lock;
        logic                pll_lock_status;
        logic                dither_enable;
        logic                clock_fail_flag;
        logic                tune_sequence_enable;
        logic                switch_request;
        logic [15:0]         oscillator_tuning;
        logic [15:0]         oscillator_tuning_two;
        logic [PRT_W-1:0]    pseudo_random_trim;
        logic [TRIM_W-1:0]   frc_trim;
    } ocr_state_t;
endpackage : ocr_pkg

/* File: logic/ocr_ctrl.sv */
// Oscillator control, tuning and pseudo-random trim registers
// Function
// - Current group read-only, reports active group
// - Current group zero on reset, loads on switch
// - Fail-safe switch forces current group zero
// - Requested group writable, reset from config
// - Lock bit plus monitor bit1 freezes requested group and switch request
// - Lock bit cannot be cleared by software
// - PLL locked set when lock achieved
// - PLL locked cleared on reset, loss, start unless PLL group and locked
// - PLL locked reads zero without PLL group
// - Dither enable bit turns dither on, resets zero
// - Fail flag set by monitor, cleared variously
// - Sequence enable picks phase-driven trim source
// - Phase index n selects sequence trim n
// - Switch request set by software, hardware clears
// - Switch request cleared on reset, redundancy
// - Base trim is two's complement
// - First tuning register field layout
// - Second tuning register field layout
// - Pseudo-random trim 15 bits, bit15 zero
// - Unimplemented control bits read zero
// - Initial group config sets power-on group
// - Monitor config gates switching and monitoring
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module ocr_ctrl #(
    parameter int PHASE_W = 3
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [ocr_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ocr_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [1:0]                  initial_group_config,
    input  wire logic [1:0]                  switch_monitor_config,
    input  wire logic                        switch_start,
    input  wire logic                        switch_done,
    input  wire logic                        fail_detect,
    input  wire logic                        pll_locked,
    input  wire logic [PHASE_W-1:0]          phase_index,
    output logic [ocr_pkg::GRP_W-1:0]        current_group,
    output logic [ocr_pkg::GRP_W-1:0]        requested_group,
    output logic                             switch_request,
    output logic                             clocks_locked,
    output logic                             switching_enabled,
    output logic                             monitor_enabled,
    output logic                             dither_on,
    output logic [ocr_pkg::PRT_W-1:0]        dither_trim,
    output logic [ocr_pkg::TRIM_W-1:0]       frc_trim
);

    ocr_pkg::ocr_state_t s;
    ocr_pkg::ocr_state_t next_s;

    // Address decode shared by read and write paths
    function automatic ocr_pkg::ocr_sel_t decode(
        input logic [ocr_pkg::ADDR_W-1:0] addr
    );
        if (addr == ocr_pkg::OFS_CONTROL)
            return ocr_pkg::SEL_CONTROL;
        else if (addr == ocr_pkg::OFS_TUNING)
            return ocr_pkg::SEL_TUNING;
        else if (addr == ocr_pkg::OFS_TUNING2)
            return ocr_pkg::SEL_TUNING2;
        else if (addr == ocr_pkg::OFS_PRTRIM)
            return ocr_pkg::SEL_PRTRIM;
        else
            return ocr_pkg::SEL_NONE;
    endfunction : decode

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] data,
        input logic [1:0]  strb
    );
        logic [15:0] r;
        r = old;
        if (strb[0])
            r[7:0] = data[7:0];
        if (strb[1])
            r[15:8] = data[15:8];
        return r;
    endfunction : merge

    function automatic logic is_pll_group(input logic [2:0] g);
        return (g == ocr_pkg::GRP_RC_PLL) || (g == ocr_pkg::GRP_PRI_PLL);
    endfunction : is_pll_group

    // One step of the pseudo-random trim sequence
    function automatic logic [ocr_pkg::PRT_W-1:0] prt_step(
        input logic [ocr_pkg::PRT_W-1:0] v
    );
        // All-zero state would lock up, so reseed it
        if (v == ocr_pkg::PRT_RESET)
            return ocr_pkg::PRT_SEED;
        else
            return {v[ocr_pkg::PRT_W-2:0],
                v[ocr_pkg::PRT_TAP_A] ^ v[ocr_pkg::PRT_TAP_B]};
    endfunction : prt_step

    logic        sw_enable;
    logic        fs_enable;
    logic        locked;
    logic        pll_stat_rd;
    logic [15:0] control_rd;
    logic [15:0] ctl_new;
    logic [3:0]  trims [8];
    logic        write_go;
    logic [15:0] prt_merged;

    assign sw_enable = !switch_monitor_config[1];
    assign fs_enable = (switch_monitor_config == 2'h0);

    assign locked = s.config_lock && switch_monitor_config[1];

    // Hide lock without PLL group
    // Status is kept whole; only the read view is masked
    assign pll_stat_rd = s.pll_lock_status && is_pll_group(s.current_group);

    // Both halves of a write held and the response slot free
    assign write_go = s.aw_held && s.w_held && !s.bvalid;

    // Trim write merged on a 16-bit view, bit 15 then dropped
    assign prt_merged = merge({1'b0, s.pseudo_random_trim},
        s.w_data, s.w_strb);

    always_comb
    begin
        control_rd = 16'h0000;
        control_rd[ocr_pkg::CUR_LSB +: ocr_pkg::GRP_W] = s.current_group;
        control_rd[ocr_pkg::REQ_LSB +: ocr_pkg::GRP_W] = s.requested_group;
        control_rd[ocr_pkg::LOCK_BIT] = s.config_lock;
        control_rd[ocr_pkg::PLLL_BIT] = pll_stat_rd;
        control_rd[ocr_pkg::DITH_BIT] = s.dither_enable;
        control_rd[ocr_pkg::FAIL_BIT] = s.clock_fail_flag;
        control_rd[ocr_pkg::TSEQ_BIT] = s.tune_sequence_enable;
        control_rd[ocr_pkg::SWRQ_BIT] = s.switch_request;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_trim
            assign trims[gi]   = s.oscillator_tuning[gi*4 +: 4];
            assign trims[gi+4] = s.oscillator_tuning_two[gi*4 +: 4];
        end
    endgenerate

    always_comb
    begin
        next_s  = s;
        ctl_new = merge(control_rd, s.w_data, s.w_strb);

        // Bus channel acceptance
        // Address and data may arrive in either order
        if (s_axi_awvalid && !s.aw_held)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_held)
        begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata[15:0];
            next_s.w_strb = s_axi_wstrb[1:0];
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;

        // Register write once address and data are both held
        // A held response blocks the next write until bready
        if (write_go)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = ocr_pkg::RESP_OKAY;
            case (decode(s.aw_addr))
                ocr_pkg::SEL_CONTROL:
                begin
                    if (!locked)
                        next_s.requested_group =
                            ctl_new[ocr_pkg::REQ_LSB +: ocr_pkg::GRP_W];
                    next_s.config_lock = s.config_lock
                        | ctl_new[ocr_pkg::LOCK_BIT];
                    next_s.dither_enable = ctl_new[ocr_pkg::DITH_BIT];
                    next_s.clock_fail_flag = s.clock_fail_flag
                        & ctl_new[ocr_pkg::FAIL_BIT];
                    next_s.tune_sequence_enable = ctl_new[ocr_pkg::TSEQ_BIT];
                    if (!locked && sw_enable && ctl_new[ocr_pkg::SWRQ_BIT])
                        next_s.switch_request = 1'b1;
                end
                ocr_pkg::SEL_TUNING:
                    next_s.oscillator_tuning = merge(s.oscillator_tuning,
                        s.w_data, s.w_strb);
                ocr_pkg::SEL_TUNING2:
                    next_s.oscillator_tuning_two = merge(
                        s.oscillator_tuning_two, s.w_data, s.w_strb);
                ocr_pkg::SEL_PRTRIM:
                    next_s.pseudo_random_trim =
                        prt_merged[ocr_pkg::PRT_W-1:0];
                default:
                    next_s.bresp = ocr_pkg::RESP_SLVERR;
            endcase
        end
        else if (s.dither_enable)
        begin
            // Advance pseudo-random trim
            // A bus write pauses the step so a new seed is not skipped
            next_s.pseudo_random_trim = prt_step(s.pseudo_random_trim);
        end

        // Read channel
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s_axi_arvalid && !s.rvalid)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = ocr_pkg::RESP_OKAY;
            case (decode(s_axi_araddr))
                ocr_pkg::SEL_CONTROL:
                    next_s.rdata = control_rd;
                ocr_pkg::SEL_TUNING:
                    next_s.rdata = s.oscillator_tuning;
                ocr_pkg::SEL_TUNING2:
                    next_s.rdata = s.oscillator_tuning_two;
                ocr_pkg::SEL_PRTRIM:
                    next_s.rdata = {1'b0, s.pseudo_random_trim};
                default:
                begin
                    next_s.rdata = 16'h0000;
                    next_s.rresp = ocr_pkg::RESP_SLVERR;
                end
            endcase
        end

        if (s.switch_request && s.requested_group == s.current_group)
            next_s.switch_request = 1'b0;

        if (switch_done)
        begin
            next_s.current_group  = s.requested_group;
            next_s.switch_request = 1'b0;
        end

        if (switch_start)
        begin
            next_s.pll_lock_status = 1'b0;
            next_s.clock_fail_flag = 1'b0;
        end

        // Set on lock, clear on loss
        if (!pll_locked)
            next_s.pll_lock_status = 1'b0;
        else if (is_pll_group(s.current_group))
            next_s.pll_lock_status = 1'b1;

        if (fail_detect && fs_enable)
        begin
            next_s.current_group   = ocr_pkg::GRP_RC;
            next_s.switch_request  = 1'b0;
            next_s.clock_fail_flag = 1'b1;
        end

        // Base trim is signed, passed as is
        // Registered so the trim bus never glitches
        if (s.tune_sequence_enable)
            next_s.frc_trim = trims[phase_index];
        else
            next_s.frc_trim = trims[ocr_pkg::PHASE_BASE];

        if (!aresetn)
        begin
            next_s = '0;
            next_s.current_group = ocr_pkg::GRP_RC;
            // Power-on requested group
            // Strap only matters while reset is held
            next_s.requested_group = {1'b0, initial_group_config};
            next_s.bresp = ocr_pkg::RESP_OKAY;
            next_s.rresp = ocr_pkg::RESP_OKAY;
            next_s.pseudo_random_trim = ocr_pkg::PRT_RESET;
        end
    end

    always_ff @(posedge aclk)
    begin
        s <= next_s;
    end

    assign s_axi_awready     = !s.aw_held;
    assign s_axi_wready      = !s.w_held;
    assign s_axi_bvalid      = s.bvalid;
    assign s_axi_bresp       = s.bresp;
    assign s_axi_arready     = !s.rvalid;
    assign s_axi_rvalid      = s.rvalid;
    assign s_axi_rresp       = s.rresp;
    assign s_axi_rdata       = {16'h0000, s.rdata};
    assign current_group     = s.current_group;
    assign requested_group   = s.requested_group;
    assign switch_request    = s.switch_request;
    assign clocks_locked     = locked;
    assign switching_enabled = sw_enable;
    assign monitor_enabled   = fs_enable;
    assign dither_on         = s.dither_enable;
    assign dither_trim       = s.dither_enable ? s.pseudo_random_trim
                                               : ocr_pkg::PRT_RESET;
    assign frc_trim          = s.frc_trim;

endmodule : ocr_ctrl

/* File: tb/ocr_ctrl_sva.sv */
// Assertions on the oscillator control register block ports
`timescale 1ns/1ns
module ocr_ctrl_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_wvalid,
    input wire logic [1:0]  switch_monitor_config,
    input wire logic        switch_done,
    input wire logic        fail_detect,
    input wire logic [2:0]  current_group,
    input wire logic [2:0]  requested_group,
    input wire logic        switch_request,
    input wire logic        clocks_locked,
    input wire logic        switching_enabled,
    input wire logic        monitor_enabled,
    input wire logic        dither_on,
    input wire logic [14:0] dither_trim
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_group: assert property ($rose(aresetn) |->
        current_group == 3'h0 && !switch_request)
        else $error("group or request not cleared by reset");
    a_done_load: assert property (switch_done && !fail_detect
        && switching_enabled |=> current_group == $past(requested_group))
        else $error("current group not loaded on switch done");
    a_fail_safe: assert property (fail_detect && monitor_enabled |=>
        current_group == 3'h0 && !switch_request)
        else $error("fail-safe did not force internal rc");
    a_lock_sticky: assert property (clocks_locked
        ##1 switch_monitor_config[1] |-> clocks_locked)
        else $error("config lock cleared without reset");
    a_cfg_decode: assert property (
        switching_enabled == !switch_monitor_config[1] &&
        monitor_enabled == (switch_monitor_config == 2'h0))
        else $error("monitor config decode wrong");
    a_dither_off: assert property (!dither_on |->
        dither_trim == 15'h0)
        else $error("dither trim active while disabled");
    a_redundant_clr: assert property (switch_request &&
        requested_group == current_group && !s_axi_wvalid
        |-> ##[1:2] !switch_request)
        else $error("redundant request not cleared");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer missing");
    cover property (switch_done ##1 current_group != 3'h0);
    cover property (fail_detect && monitor_enabled);
    cover property (clocks_locked);
endmodule : ocr_ctrl_sva

bind ocr_ctrl ocr_ctrl_sva u_sva (.*);

/* File: tb/test_ocr_ctrl.sv */
// Self-checking bench for the oscillator control register block
`timescale 1ns/1ns
module test_ocr_ctrl;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic switch_start = 0, switch_done = 0, fail_detect = 0;
    logic pll_locked = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, phase_index = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, frc_trim;
    logic [1:0] initial_group_config = 2'h1, switch_monitor_config = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, switch_request, clocks_locked, switching_enabled;
    logic monitor_enabled, dither_on;
    logic [2:0] current_group, requested_group;
    logic [14:0] dither_trim, p;
    logic [15:0] t1, t2;
    logic [31:0] d;
    int num_errors = 0, n_checks = 0;

    ocr_ctrl uut (.*);

    always #20 aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ar, r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        while (!r)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask : rdchk

    // Pulse of {switch_start, switch_done, fail_detect}
    task automatic ev(input logic [2:0] m);
        @(posedge aclk);
        {switch_start, switch_done, fail_detect} <= m;
        @(posedge aclk);
        {switch_start, switch_done, fail_detect} <= 3'h0;
        repeat (2) @(negedge aclk);
    endtask : ev

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask : endt

    function automatic logic [3:0] etrim(input logic [2:0] ph);
        logic [31:0] all;
        all = {t2, t1};
        return all[ph*4 +: 4];
    endfunction : etrim

    function automatic logic [14:0] nx(input logic [14:0] x);
        return {x[13:0], x[14] ^ x[13]};
    endfunction : nx

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    initial
    begin
        #(40 * 6000);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(19));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(8'h00, 32'h0100);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h0);
        rdchk(8'h0c, 32'h0);
        endt("reset");
        t1 = 16'($urandom);
        t2 = 16'($urandom);
        wr(8'h04, t1);
        wr(8'h08, t2);
        rdchk(8'h04, {16'h0, t1});
        rdchk(8'h08, {16'h0, t2});
        wr(8'h0c, 16'hffff);
        rdchk(8'h0c, 32'h7fff);
        wr(8'h00, 16'hfb76);
        rdchk(8'h00, 32'h0314);
        endt("layout");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge aclk) phase_index <= 3'(i);
            repeat (2) @(negedge aclk);
            chk(32'(frc_trim), 32'(etrim(3'(i))));
        end
        p = dither_trim;
        @(negedge aclk);
        chk(32'(dither_trim), 32'(nx(p)));
        wr(8'h00, 16'h0301);
        chk(32'(dither_on), 32'h0);
        @(posedge aclk) phase_index <= 3'($urandom);
        repeat (2) @(negedge aclk);
        chk(32'(frc_trim), 32'(t1[3:0]));
        endt("trim");
        chk(32'(switch_request), 32'h1);
        ev(3'h4);
        ev(3'h2);
        chk({current_group, switch_request}, {3'h3, 1'b0});
        rdchk(8'h00, 32'h3320);
        @(posedge aclk) pll_locked <= 1'b0;
        rdchk(8'h00, 32'h3300);
        pll_locked <= 1'b1;
        ev(3'h1);
        rdchk(8'h00, 32'h0308);
        wr(8'h00, 16'h0300);
        rdchk(8'h00, 32'h0300);
        endt("switch");
        wr(8'h00, 16'h0001);
        @(negedge aclk);
        chk(32'(switch_request), 32'h0);
        switch_monitor_config <= 2'h2;
        wr(8'h00, 16'h0080);
        chk(32'(clocks_locked), 32'h1);
        chk(32'(switching_enabled), 32'h0);
        chk(32'(monitor_enabled), 32'h0);
        wr(8'h00, 16'h0201);
        rdchk(8'h00, 32'h0080);
        endt("lock");
        wr(8'h10, 16'h1234);
        chk(32'(rs), 32'h2);
        rdchk(8'h10, 32'h0);
        chk(32'(rs), 32'h2);
        initial_group_config <= 2'h2;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(8'h00, 32'h0200);
        chk(32'(requested_group), 32'h2);
        endt("unmapped and reset");
        give_verdict();
    end
endmodule : test_ocr_ctrl
